// ### cst_params.svh
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH
// Behaviour
// (R1) Adapter-ok pin low while adapter level is below battery level.
// (R2) Charge time is one hour times resistor over 154K; no resistor, no start.
// (R3) Error pin low on conditioning failure or thermistor suspension.
// (R4) Cell count pin high selects four cells, low selects three.
// (R5) Low-cell pin low under 3.25V/cell, or 3.173V/cell for lower grade.
// (R6) Unsafe thermistor suspends charging and timer and pulls error low.
// (R7) Input-limit pin low while input limiting reduces charge current.
// (R8) Grade pin low picks 4.1V cells, open or high picks 4.2V.
// (R9) Taper pin latches low at 10% current and holds until cleared.
// (R10) Shutdown request high keeps charger off and timer reset.
// (R11) Host pulses shutdown high for at least 0.1us to reset.
// (R12) Charging pin low while charging, released otherwise.
// (R13) Charging pin forced below 1V disables timer and its timeouts.
// (R14) Float target is 12.3V, 12.6V, 16.4V or 16.8V by count and grade.
// (R15) Start needs adapter above battery, lockout clear, shutdown low.
// (R16) Low cell lasting a quarter of charge time ends charge with error.
// (R17) Thermistor sampled periodically; acceptable value resumes charge.
// (R18) Taper assertion reloads timer so one quarter of time remains.
// (R19) Taper indication inhibited while input limiting is active.
// (R20) Timer expiry ends charging and releases the charging pin.
// (R21) Host restarts by reapplying adapter or pulsing shutdown.
// (R22) Without adapter the charger sleeps and stops charging.
// (R23) All comparator and pin inputs pass a two-stage synchroniser.

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CST_CLK_HZ          100000000
`define CST_HOUR_S          3600
`define CST_RT_REF_KOHM     154
`define CST_UNIT_CYCLES     (64'd3600 * 64'd100000000 / 64'd154)
`define CST_THERM_SAMPLE_US 1000
`define CST_THERM_CYCLES    (`CST_THERM_SAMPLE_US * (`CST_CLK_HZ / 1000000))
`define CST_RT_WIDTH        16
`define CST_PRE_WIDTH       36
`define CST_TH_WIDTH        24
`endif

// ### cst_pkg.sv
package cst_pkg;
  // Synchronised inputs from comparators and strap pins.
  typedef struct packed {
    logic adapterAboveBat;
    logic undervoltageLockout;
    logic lowCell;
    logic thermUnsafe;
    logic taperCmp;
    logic inputLimiting;
    logic rtPresent;
    logic cellCountSelect;
    logic cellVoltageGradeSelect;
    logic shutdownRequest;
    logic timerDefeat;
  } cst_pins_t;

  // Active-low indicator levels: 0 pulls the pin low, 1 releases it.
  typedef struct packed {
    logic adapterOkN;
    logic chargingActiveN;
    logic lowCellIndicatorN;
    logic taperDetectN;
    logic inputLimitActiveN;
    logic errorOutN;
  } cst_status_t;

  typedef enum logic [1:0] {
    FLOAT_12V3, FLOAT_12V6, FLOAT_16V4, FLOAT_16V8
  } cst_float_t;

  typedef enum logic {LOWTH_3V25, LOWTH_3V173} cst_lowth_t;

  typedef enum {
    ST_SLEEP, ST_SHUT, ST_COND, ST_CHARGE, ST_DONE, ST_FAULT
  } cst_state_e_t;
endpackage : cst_pkg

// ### cst_charge_sequence_control.sv
`timescale 1ns/1ns
`include "cst_params.svh"

module cst_charge_sequence_control #(
  parameter logic [`CST_PRE_WIDTH-1:0] UNIT_CYCLES =
    `CST_PRE_WIDTH'(`CST_UNIT_CYCLES),
  parameter logic [`CST_TH_WIDTH-1:0] THERM_CYCLES =
    `CST_TH_WIDTH'(`CST_THERM_CYCLES)
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Comparator results and pin levels, asynchronous to clk.
  input  wire cst_pkg::cst_pins_t       pinsIn,
  input  wire logic [`CST_RT_WIDTH-1:0] rtKohm,
  // Indicator pin levels.
  output       cst_pkg::cst_status_t    status,
  // Controls for the analog loop.
  output logic                          chargeEnable,
  output logic                          sleepMode,
  output       cst_pkg::cst_float_t     floatTarget,
  output       cst_pkg::cst_lowth_t     lowCellThreshold
);
  import cst_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    cst_pins_t                 sync1;
    cst_pins_t                 sync2;
    logic [`CST_RT_WIDTH-1:0]  rtSync1;
    logic [`CST_RT_WIDTH-1:0]  rtSync2;
    logic [`CST_RT_WIDTH-1:0]  total;
    cst_state_e_t              st;
    logic [`CST_PRE_WIDTH-1:0] pre;
    logic [`CST_RT_WIDTH-1:0]  elapsed;
    logic [`CST_TH_WIDTH-1:0]  thCnt;
    logic                      thermBad;
    logic                      taper;
    cst_status_t               out;
    logic                      chargeEnable;
    logic                      sleepMode;
    cst_float_t                floatTarget;
    cst_lowth_t                lowTh;
  } cst_core_t;

  cst_core_t cur_ff;
  cst_core_t nxt_cur;

  // Float target from cell count and grade.
  function automatic cst_float_t floatOf(input logic four,
                                         input logic hiGrade);
    cst_float_t f;
    f = FLOAT_12V3;
    case ({four, hiGrade}) // [R14]
      2'b00:   f = FLOAT_12V3;
      2'b01:   f = FLOAT_12V6;
      2'b10:   f = FLOAT_16V4;
      default: f = FLOAT_16V8;
    endcase
    return f;
  endfunction : floatOf

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Aliases for the synchronised view; only the second stage is read.
  cst_pins_t p;
  logic      running;
  logic      unitTick;
  logic      thermTick;
  logic      timerOn;
  logic      taperSet;
  logic      seqFree;
  logic [`CST_RT_WIDTH-1:0] quarter;

  always_comb begin
    p        = cur_ff.sync2;
    quarter  = {2'b00, cur_ff.total[`CST_RT_WIDTH-1:2]};
    running  = (cur_ff.st == ST_COND) || (cur_ff.st == ST_CHARGE);
    timerOn  = running && !cur_ff.thermBad && !p.timerDefeat; // [R6] [R13]
    unitTick = timerOn && (cur_ff.pre == UNIT_CYCLES - 1'b1);
    thermTick = (cur_ff.thCnt == THERM_CYCLES - 1'b1);
    // Sequencing is free of the adapter, shutdown, lockout and missing-resistor overrides.
    seqFree  = p.adapterAboveBat && !p.shutdownRequest &&
               !p.undervoltageLockout && p.rtPresent;
    // Current decline under input limiting does not count as taper.
    taperSet = (cur_ff.st == ST_CHARGE) && !cur_ff.taper &&
               p.taperCmp && !p.inputLimiting &&
               !cur_ff.thermBad;                                // [R9] [R19]

    nxt_cur = cur_ff;
    // Two flip-flops before any logic sees a pin.
    nxt_cur.sync1   = pinsIn;                                    // [R23]
    nxt_cur.sync2   = cur_ff.sync1;                              // [R23]
    nxt_cur.rtSync1 = rtKohm;
    nxt_cur.rtSync2 = cur_ff.rtSync1;

    // Thermistor is sampled on a fixed interval, not watched every cycle,
    // so a brief glitch between samples cannot pause the charge.
    nxt_cur.thCnt = thermTick ? '0 : cur_ff.thCnt + 1'b1;
    if (thermTick) begin
      nxt_cur.thermBad = p.thermUnsafe;                          // [R17]
    end

    // Unit prescaler runs only while the timer counts.
    if (!timerOn || unitTick) begin
      nxt_cur.pre = '0;
    end else begin
      nxt_cur.pre = cur_ff.pre + 1'b1;
    end
    if (unitTick && cur_ff.elapsed != cur_ff.total) begin
      nxt_cur.elapsed = cur_ff.elapsed + 1'b1;
    end

    // Sequencing; adapter loss and shutdown override everything.
    if (!p.adapterAboveBat) begin
      nxt_cur.st      = ST_SLEEP;                                // [R22]
      nxt_cur.elapsed = '0;
      nxt_cur.taper   = 1'b0;
    end else if (p.shutdownRequest || p.undervoltageLockout ||
                 !p.rtPresent) begin
      nxt_cur.st      = ST_SHUT;                                 // [R10] [R2]
      nxt_cur.elapsed = '0;
      nxt_cur.taper   = 1'b0;
    end else begin
      case (cur_ff.st)
        ST_SLEEP, ST_SHUT: begin
          // Resistor value is taken once at start and held for the cycle.
          nxt_cur.total   = cur_ff.rtSync2;                      // [R2]
          nxt_cur.elapsed = '0;
          nxt_cur.pre     = '0;
          nxt_cur.st      = p.lowCell ? ST_COND : ST_CHARGE;     // [R15]
        end
        ST_COND: begin
          if (!p.timerDefeat && cur_ff.elapsed >= quarter) begin
            nxt_cur.st = ST_FAULT;                               // [R16]
          end else if (!p.lowCell) begin
            nxt_cur.st = ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (taperSet) begin
            nxt_cur.taper   = 1'b1;                              // [R9]
            nxt_cur.elapsed = cur_ff.total - quarter;            // [R18]
          end else if (!p.timerDefeat &&
                       cur_ff.elapsed == cur_ff.total) begin
            nxt_cur.st = ST_DONE;                                // [R20]
          end
        end
        ST_DONE, ST_FAULT: begin
          // Finished; only adapter loss, shutdown, lockout or resistor removal restarts.   [R21]
          nxt_cur.st = cur_ff.st;
        end
        default: nxt_cur.st = ST_SHUT;
      endcase
    end

    // Outputs, registered from the decided next state and the synchronised pins.
    nxt_cur.out.adapterOkN        = p.adapterAboveBat;           // [R1]
    nxt_cur.out.chargingActiveN   = !((nxt_cur.st == ST_COND) ||
                                      (nxt_cur.st == ST_CHARGE)); // [R12]
    nxt_cur.out.lowCellIndicatorN = !p.lowCell;                  // [R5]
    nxt_cur.out.taperDetectN      = !nxt_cur.taper;              // [R9]
    nxt_cur.out.inputLimitActiveN = !p.inputLimiting;            // [R7]
    nxt_cur.out.errorOutN = !((nxt_cur.st == ST_FAULT) ||
                              (!nxt_cur.out.chargingActiveN &&
                               nxt_cur.thermBad));                // [R3]
    nxt_cur.chargeEnable = !nxt_cur.out.chargingActiveN &&
                           !nxt_cur.thermBad;                     // [R6]
    nxt_cur.sleepMode   = (nxt_cur.st == ST_SLEEP);              // [R22]
    nxt_cur.floatTarget = floatOf(p.cellCountSelect,
                                  p.cellVoltageGradeSelect);     // [R4] [R8]
    nxt_cur.lowTh = p.cellVoltageGradeSelect ? LOWTH_3V25
                                             : LOWTH_3V173;      // [R5]
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff                       <= '0;
      cur_ff.st                    <= ST_SLEEP;
      cur_ff.out                   <= '1;
      cur_ff.out.adapterOkN        <= 1'b0;
      cur_ff.sleepMode             <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign status           = cur_ff.out;
  assign chargeEnable     = cur_ff.chargeEnable;
  assign sleepMode        = cur_ff.sleepMode;
  assign floatTarget      = cur_ff.floatTarget;
  assign lowCellThreshold = cur_ff.lowTh;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Adapter-ok follows the synchronised comparator one edge later.
  chk_adapter_ok_level: assert property ( // [R1]
    cur_ff.sync2.adapterAboveBat |=> status.adapterOkN
  ) else $error("adapter ok pin pulled low while adapter above battery");

  // No resistor means no charging three edges after the pin goes low.
  chk_no_rt_start: assert property ( // [R2]
    (!pinsIn.rtPresent) [*3] |=> status.chargingActiveN
  ) else $error("charging with no timer resistor");

  // Thermistor pause holds error low and power off.
  chk_therm_error: assert property ( // [R3] [R6]
    (!status.chargingActiveN && cur_ff.thermBad) |->
      (!status.errorOutN && !chargeEnable)
  ) else $error("thermistor pause without error or with power on");

  // Timer frozen while paused.
  chk_timer_paused: assert property ( // [R6]
    (cur_ff.thermBad && $stable(cur_ff.st) && seqFree) |=>
      $stable(cur_ff.elapsed)
  ) else $error("charge timer advanced during thermistor pause");

  // Input-limit indicator tracks the comparator.
  chk_limit_level: assert property ( // [R7]
    cur_ff.sync2.inputLimiting |=> !status.inputLimitActiveN
  ) else $error("input limit pin not low while limiting");

  // Float decode from strap pins.
  chk_float_decode: assert property ( // [R4] [R8] [R14]
    (cur_ff.sync2.cellCountSelect && cur_ff.sync2.cellVoltageGradeSelect)
      |=> floatTarget == FLOAT_16V8
  ) else $error("four cells at high grade did not give top float");

  // Taper latch holds until shutdown, lockout, resistor removal or adapter loss.
  chk_taper_hold: assert property ( // [R9]
    (!status.taperDetectN && cur_ff.sync2.adapterAboveBat &&
     !cur_ff.sync2.shutdownRequest && !cur_ff.sync2.undervoltageLockout &&
     cur_ff.sync2.rtPresent) |=> !status.taperDetectN
  ) else $error("taper latch dropped without being cleared");

  // Shutdown forces idle and a cleared timer.
  chk_shutdown_idle: assert property ( // [R10]
    (cur_ff.sync2.shutdownRequest && cur_ff.sync2.adapterAboveBat) |=>
      (cur_ff.elapsed == '0 && status.chargingActiveN)
  ) else $error("shutdown did not stop charging and clear timer");

  // Defeated timer never advances.
  chk_defeat_timer: assert property ( // [R13]
    (cur_ff.sync2.timerDefeat && cur_ff.st == ST_CHARGE && !taperSet &&
     seqFree) |=> $stable(cur_ff.elapsed)
  ) else $error("timer advanced while defeated");

  // Taper reloads the timer to three quarters elapsed.
  chk_taper_reload: assert property ( // [R18] [R19]
    taperSet && cur_ff.sync2.adapterAboveBat &&
    !cur_ff.sync2.shutdownRequest && !cur_ff.sync2.undervoltageLockout &&
    cur_ff.sync2.rtPresent |=>
      cur_ff.elapsed == $past(cur_ff.total) - ($past(cur_ff.total) >> 2)
  ) else $error("taper did not reload quarter of charge time");

  // Quarter-time in conditioning ends in fault.
  chk_cond_fault: assert property ( // [R16]
    (cur_ff.st == ST_COND && !cur_ff.sync2.timerDefeat &&
     cur_ff.elapsed >= quarter && cur_ff.sync2.adapterAboveBat &&
     !cur_ff.sync2.shutdownRequest && !cur_ff.sync2.undervoltageLockout &&
     cur_ff.sync2.rtPresent) |=> (!status.errorOutN && status.chargingActiveN)
  ) else $error("conditioning overrun did not fault");

  // Expiry ends the charge and releases the pin.
  chk_expiry_done: assert property ( // [R20] [R12]
    cur_ff.st == ST_DONE |-> (status.chargingActiveN && !chargeEnable)
  ) else $error("charging pin held low after timer expiry");

  // Adapter gone puts the charger to sleep one edge after the synchronised comparator drops.
  chk_sleep_entry: assert property ( // [R22]
    !cur_ff.sync2.adapterAboveBat |=> (sleepMode && !chargeEnable)
  ) else $error("no sleep without adapter");

  // Start needs adapter above battery and shutdown low.
  chk_start_gate: assert property ( // [R15]
    ($past(cur_ff.st) inside {ST_SLEEP, ST_SHUT}) && !status.chargingActiveN
      |-> $past(cur_ff.sync2.adapterAboveBat, 1) &&
          !$past(cur_ff.sync2.shutdownRequest, 1)
  ) else $error("charging began without start conditions");

  // Input passes two stages before the state sees it.
  chk_sync_depth: assert property ( // [R23]
    $rose(pinsIn.adapterAboveBat) [*1] ##1 $stable(pinsIn.adapterAboveBat)
      |-> !$rose(cur_ff.sync2.adapterAboveBat)
  ) else $error("input reached logic without two flip-flops");

  // Threshold select follows grade.
  chk_lowth_grade: assert property ( // [R5]
    !cur_ff.sync2.cellVoltageGradeSelect |=> lowCellThreshold == LOWTH_3V173
  ) else $error("low cell threshold not lowered for lower grade");

  // Charging pin is low exactly while conditioning or charging.
  chk_charge_pin_state: assert property ( // [R12]
    status.chargingActiveN ==
      !(cur_ff.st inside {ST_COND, ST_CHARGE})
  ) else $error("charging pin disagrees with charge state");

  // Limiting keeps a clear taper latch clear.
  chk_limit_no_taper: assert property ( // [R19]
    (cur_ff.sync2.inputLimiting && status.taperDetectN) |=>
      status.taperDetectN
  ) else $error("taper latched while input limiting");

  // A qualified taper sets the latch on the next edge.
  chk_taper_set: assert property ( // [R9]
    (taperSet && seqFree) |=> !status.taperDetectN
  ) else $error("taper latch not set");

  // Thermistor state changes only on a sampling tick.
  chk_therm_sample: assert property ( // [R17]
    !thermTick |=> $stable(cur_ff.thermBad)
  ) else $error("thermistor state changed between samples");

  // Cool battery while charging: error released and power on.
  chk_therm_resume: assert property ( // [R17]
    (!status.chargingActiveN && !cur_ff.thermBad) |->
      (status.errorOutN && chargeEnable)
  ) else $error("charge not resumed after thermistor recovered");

  // Resistor value is frozen once a charge has started.
  chk_total_held: assert property ( // [R2]
    (cur_ff.st inside {ST_COND, ST_CHARGE}) |=> $stable(cur_ff.total)
  ) else $error("charge time changed during a charge");

  // Defeated timer cannot end conditioning in a fault.
  chk_defeat_no_fault: assert property ( // [R13] [R16]
    (cur_ff.sync2.timerDefeat && cur_ff.st == ST_COND) |=>
      cur_ff.st != ST_FAULT
  ) else $error("conditioning fault while timer defeated");

  // Elapsed reaching total in charge ends the charge.
  chk_expiry_entry: assert property ( // [R20]
    (cur_ff.st == ST_CHARGE && cur_ff.elapsed == cur_ff.total &&
     !cur_ff.sync2.timerDefeat && !taperSet && seqFree) |=>
      cur_ff.st == ST_DONE
  ) else $error("timer expiry did not end the charge");

endmodule : cst_charge_sequence_control

// ### cst_host_model.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Host side of the charger: watches indicators, drives controls
// ---------------------------------------------------------------
module cst_host_model (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Indicator levels from the charger.
  input  wire cst_pkg::cst_status_t status,
  // Host controls.
  output logic                      shutdownRequest,
  output logic                      timerDefeat
);
  import cst_pkg::*;

  logic cycleSeen_ff;

  initial begin
    shutdownRequest = 1'b0;
    timerDefeat     = 1'b0;
  end

  // Remembers that a charge ran, so a restart is known to be due.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cycleSeen_ff <= 1'b0;
    end else if (!status.chargingActiveN) begin
      cycleSeen_ff <= 1'b1;
    end
  end

  // Held for the given number of cycles, twelve at each call: a brief pulse may slip
  // past the charger's input synchroniser.
  task automatic pulse_shutdown(input int cycles);
    @(posedge clk);
    shutdownRequest <= 1'b1;
    repeat (cycles) @(posedge clk);
    shutdownRequest <= 1'b0;
  endtask : pulse_shutdown

  // Pulling the charging pin low is read by the charger as defeat.
  task automatic force_defeat(input logic on);
    @(posedge clk);
    timerDefeat <= on;
  endtask : force_defeat
endmodule : cst_host_model

// ### tb_top.sv
`timescale 1ns/1ns
`include "cst_params.svh"

module tb_top;
  import cst_pkg::*;

  // ---------------------------------------------------------------
  // Clock, stimulus and instances
  // ---------------------------------------------------------------
  logic                     clk = 1'b0;
  logic                     rstn = 1'b0;
  cst_pins_t                pins;
  cst_pins_t                pinsAll;
  logic [`CST_RT_WIDTH-1:0] rtKohm = 16'h0020;
  cst_status_t              status;
  logic                     chargeEnable;
  logic                     sleepMode;
  logic                     hostShut;
  logic                     hostDefeat;
  cst_float_t               floatTarget;
  cst_lowth_t               lowCellThreshold;
  int                       failures = 0;
  int                       samplesChecked = 0;
  int                       cycleCount = 0;

  always #5 clk = ~clk;

  // The host owns shutdown and defeat; the bench owns the rest.
  always_comb begin
    pinsAll = pins;
    pinsAll.shutdownRequest = hostShut;
    pinsAll.timerDefeat = hostDefeat;
  end

  // Unit of eight clocks; 32 resistor units give a 256-clock charge.
  cst_charge_sequence_control #(
    .UNIT_CYCLES (36'h8),
    .THERM_CYCLES(24'h4)
  ) u_cst_charge_sequence_control (
    .clk(clk), .rstn(rstn), .pinsIn(pinsAll), .rtKohm(rtKohm),
    .status(status), .chargeEnable(chargeEnable),
    .sleepMode(sleepMode), .floatTarget(floatTarget),
    .lowCellThreshold(lowCellThreshold)
  );

  cst_host_model u_cst_host_model (
    .clk(clk), .rstn(rstn), .status(status),
    .shutdownRequest(hostShut), .timerDefeat(hostDefeat)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Samples 1 ns after the edge so that edge's updates have landed.
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitc

  task automatic chk(input string what, input logic [5:0] exp,
                     input logic [5:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic charging_active_n(input logic en, input logic actN);
    chk("enable", {5'h00, en}, {5'h00, chargeEnable});
    chk("chargingN", {5'h00, actN}, {5'h00, status.chargingActiveN});
  endtask : charging_active_n

  task automatic conclude();
    if (failures == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // A hang is cut short well beyond the roughly 1400 cycles needed.
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 3000) begin
      failures++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    pins = '0;
    pins.rtPresent = 1'b1;
    pins.cellCountSelect = 1'b1;
    pins.cellVoltageGradeSelect = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    waitc(1);
    chk("status", 6'h1F, status);
    chk("sleep", 6'h01, sleepMode);
    @(posedge clk);
    pins.adapterAboveBat <= 1'b1;
    pins.undervoltageLockout <= 1'b1;
    waitc(6);
    chk("adapterOk", 6'h01, status.adapterOkN);
    charging_active_n(1'b0, 1'b1);
    @(posedge clk);
    pins.undervoltageLockout <= 1'b0;
    waitc(2);
    chk("chargingN", 6'h01, status.chargingActiveN);
    waitc(2);
    charging_active_n(1'b1, 1'b0);
    chk("sleep", 6'h00, sleepMode);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pins.cellCountSelect <= i[1];
      pins.cellVoltageGradeSelect <= i[0];
      waitc(5);
      chk("float", 6'(i), floatTarget);
      chk("lowTh", {5'h00, ~i[0]}, lowCellThreshold);
    end
    // Taper while limiting is ignored; once latched, 1/4 remains.
    @(posedge clk);
    pins.inputLimiting <= 1'b1;
    pins.taperCmp <= 1'b1;
    waitc(8);
    chk("limitN", 6'h00, status.inputLimitActiveN);
    chk("taperN", 6'h01, status.taperDetectN);
    @(posedge clk);
    pins.inputLimiting <= 1'b0;
    waitc(6);
    chk("limitN", 6'h01, status.inputLimitActiveN);
    chk("taperN", 6'h00, status.taperDetectN);
    @(posedge clk);
    pins.taperCmp <= 1'b0;
    waitc(40);
    chk("taperN", 6'h00, status.taperDetectN);
    charging_active_n(1'b1, 1'b0);
    waitc(40);
    charging_active_n(1'b0, 1'b1);
    fork
      u_cst_host_model.pulse_shutdown(12);
      begin
        waitc(8);
        charging_active_n(1'b0, 1'b1);
      end
    join
    waitc(6);
    chk("taperN", 6'h01, status.taperDetectN);
    charging_active_n(1'b1, 1'b0);
    @(posedge clk);
    pins.thermUnsafe <= 1'b1;
    waitc(10);
    chk("errorN", 6'h00, status.errorOutN);
    charging_active_n(1'b0, 1'b0);
    @(posedge clk);
    pins.thermUnsafe <= 1'b0;
    waitc(10);
    chk("errorN", 6'h01, status.errorOutN);
    charging_active_n(1'b1, 1'b0);
    waitc(220);
    charging_active_n(1'b1, 1'b0);
    waitc(60);
    charging_active_n(1'b0, 1'b1);
    // Adapter loss restarts; a lasting low cell ends in a fault.
    @(posedge clk);
    pins.adapterAboveBat <= 1'b0;
    pins.lowCell <= 1'b1;
    rtKohm <= 16'h0040;
    waitc(6);
    chk("adapterOk", 6'h00, status.adapterOkN);
    chk("sleep", 6'h01, sleepMode);
    charging_active_n(1'b0, 1'b1);
    @(posedge clk);
    pins.adapterAboveBat <= 1'b1;
    waitc(40);
    chk("lowCellN", 6'h00, status.lowCellIndicatorN);
    chk("errorN", 6'h01, status.errorOutN);
    chk("chargingN", 6'h00, status.chargingActiveN);
    waitc(40);
    chk("chargingN", 6'h00, status.chargingActiveN);
    waitc(60);
    chk("errorN", 6'h00, status.errorOutN);
    chk("chargingN", 6'h01, status.chargingActiveN);
    // With the timer defeated neither fault nor expiry may occur.
    u_cst_host_model.force_defeat(1'b1);
    u_cst_host_model.pulse_shutdown(12);
    waitc(150);
    chk("errorN", 6'h01, status.errorOutN);
    @(posedge clk);
    pins.lowCell <= 1'b0;
    waitc(600);
    charging_active_n(1'b1, 1'b0);
    u_cst_host_model.force_defeat(1'b0);
    @(posedge clk);
    pins.rtPresent <= 1'b0;
    waitc(6);
    charging_active_n(1'b0, 1'b1);
    conclude();
  end
endmodule : tb_top
